// ===== logic/block_ram_fifo.sv
/*
 * block memory with two ports and a fifo mode, plus the output buffer.
 * assumes every input is synchronous to sys_clk; the write and read side
 * clocks of the fifo arrive as one-cycle tick pulses on sys_clk.
 */
`timescale 1ns/1ns
`include "block_ram_fifo_map.svh"

// ==================================================
// small fifo buffer on the read data path
module fifo_buf #(
    parameter int WIDTH = `BRF_DATA_W,
    parameter int DEPTH = `BRF_BUF_DEPTH
) (
    input wire logic sys_clk, // system clock
    input wire logic srst, // sync reset, high
    input wire logic clear, // flush contents
    input wire logic inValid, // word offered
    output logic inReady, // room for a word
    input wire logic [WIDTH-1:0] inData, // word in
    output logic outValid, // word available
    input wire logic outReady, // drain accepts
    output logic [WIDTH-1:0] outData // oldest word
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("fifo_buf depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH]; // word storage
    logic [PW:0] wrPtr_ff; // fill pointer, wrap bit on top
    logic [PW:0] rdPtr_ff; // drain pointer, wrap bit on top

    // full when pointers differ only in the wrap bit
    wire logic isEmpty = (wrPtr_ff == rdPtr_ff);
    wire logic isFull = (wrPtr_ff[PW] != rdPtr_ff[PW]) &&
                        (wrPtr_ff[PW-1:0] == rdPtr_ff[PW-1:0]);
    wire logic push = inValid && !isFull;
    wire logic pop = outReady && !isEmpty;

    assign inReady = !isFull;
    assign outValid = !isEmpty;
    assign outData = store[rdPtr_ff[PW-1:0]];

    // pointers
    always_ff @(posedge sys_clk) begin
        if (srst || clear) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            if (push) wrPtr_ff <= wrPtr_ff + (PW+1)'(1);
            if (pop) rdPtr_ff <= rdPtr_ff + (PW+1)'(1);
        end
    end

    // storage has no reset, only written words are ever read
    always_ff @(posedge sys_clk) begin
        if (push) store[wrPtr_ff[PW-1:0]] <= inData;
    end
endmodule : fifo_buf

// ==================================================
// block memory top
module block_ram_fifo import block_ram_fifo_pkg::*; #(
    parameter int ADDR_W = `BRF_ADDR_W,
    parameter int DATA_W = `BRF_DATA_W,
    parameter int BUF_DEPTH = `BRF_BUF_DEPTH,
    parameter bit ASYNC_OUT_CLEAR = 1'b0
) (
    input wire logic sys_clk, // system clock, 25 MHz
    input wire logic srst, // sync reset, high
    input wire logic chipWideResetN, // clears both outputs, low
    // port a
    input wire port_ctl_t portACtl, // port a controls
    input wire logic [ADDR_W-1:0] portAAddr, // port a address
    input wire logic [DATA_W-1:0] portAWData, // port a write data
    input wire logic portAOutputClear, // port a output clear
    output logic [DATA_W-1:0] portARData, // port a data out
    // port b
    input wire port_ctl_t portBCtl, // port b controls
    input wire logic [ADDR_W-1:0] portBAddr, // port b address
    input wire logic [DATA_W-1:0] portBWData, // port b write data
    input wire logic portBOutputClear, // port b output clear
    output logic [DATA_W-1:0] portBRData, // port b data out
    // fifo
    input wire logic fifoMode, // memory runs as fifo
    input wire logic fifoReset, // global fifo reset
    input wire logic readPointerRewind, // read pointer back to start
    input wire logic writeSideClock, // write side tick
    input wire logic writeClockEnable, // write side enable
    input wire logic writeStrobe, // write a word
    input wire logic [DATA_W-1:0] writeData, // fifo write data
    input wire logic readSideClock, // read side tick
    input wire logic readClockEnable, // read side enable
    input wire logic fetchStrobe, // fetch a word
    input wire logic [ADDR_W-1:0] fullThr, // full threshold
    input wire logic [ADDR_W-1:0] nearlyFullThr, // nearly-full level
    input wire logic [ADDR_W-1:0] nearlyEmptyThr, // nearly-empty level
    output fifo_flags_t fifoFlags, // status flags
    output logic fetchReady, // fetch would be taken
    output logic readValid, // buffered word available
    input wire logic readReady, // drain accepts word
    output logic [DATA_W-1:0] readData // buffered word
);
    localparam int DEPTH = 1 << ADDR_W;
    // value an output latch takes when cleared
    localparam logic [DATA_W-1:0] OUT_RST = {DATA_W{`BRF_OUT_RST}};
    // value both fifo pointers take on reset
    localparam logic [ADDR_W:0] PTR_RST = {(ADDR_W+1){`BRF_PTR_RST}};

    generate
        if (ADDR_W < 2 || ADDR_W > 16 || DATA_W < 1) begin : g_chk
            $error("block_ram_fifo: unsupported width");
        end
    endgenerate

    // ==================================================
    // threshold clamp, shared by all flag levels
    function automatic logic [ADDR_W-1:0] clampThr(
        input logic [ADDR_W-1:0] val,
        input logic [ADDR_W-1:0] hi
    );
        if (val == '0) clampThr = {{(ADDR_W-1){1'b0}}, 1'b1};
        else if (val > hi) clampThr = hi;
        else clampThr = val;
    endfunction : clampThr

    logic [DATA_W-1:0] mem [DEPTH]; // the memory array
    logic [ADDR_W:0] wrPtr_ff; // fifo write pointer
    logic [ADDR_W:0] rdPtr_ff; // fifo read pointer
    logic fullFlag_ff; // write side flags
    logic nearlyFullFlag_ff;
    logic emptyFlag_ff; // read side flags
    logic nearlyEmptyFlag_ff;
    logic fetchPend_ff; // word fetched, push to buffer next
    logic [DATA_W-1:0] fetchData_ff; // fetched word
    logic bufReady; // buffer has room

    // ==================================================
    // flag levels and fifo strobes
    wire logic [ADDR_W-1:0] maxThr = '1;
    wire logic [ADDR_W-1:0] fullLvl = clampThr(fullThr, maxThr);
    wire logic [ADDR_W-1:0] subLvl = (fullLvl == ADDR_W'(1)) ? fullLvl :
                                     fullLvl - ADDR_W'(1);
    wire logic [ADDR_W-1:0] nfLvl = clampThr(nearlyFullThr, subLvl);
    wire logic [ADDR_W-1:0] neLvl = clampThr(nearlyEmptyThr, subLvl);
    wire logic [ADDR_W:0] fillCount = wrPtr_ff - rdPtr_ff;
    wire logic liveFull = (fillCount >= {1'b0, fullLvl});
    wire logic liveEmpty = (fillCount == '0);
    // one fetch in flight at a time keeps buffer room honest
    wire logic fetchOk = !liveEmpty && bufReady && !fetchPend_ff;
    wire logic doWrite = fifoMode && writeSideClock && writeClockEnable &&
                         writeStrobe && !liveFull;
    wire logic doFetch = fifoMode && readSideClock && readClockEnable &&
                         fetchStrobe && fetchOk;
    // pointer and flag values after this cycle's moves
    wire logic [ADDR_W:0] nxt_wrPtr = wrPtr_ff + {{ADDR_W{1'b0}}, doWrite};
    wire logic [ADDR_W:0] nxt_rdPtr = readPointerRewind ? '0 :
                          rdPtr_ff + {{ADDR_W{1'b0}}, doFetch};
    wire logic [ADDR_W:0] nxtCount = nxt_wrPtr - nxt_rdPtr;

    assign fetchReady = fifoMode && fetchOk;
    assign fifoFlags = '{fullFlag: fullFlag_ff,
                         nearlyFullFlag: nearlyFullFlag_ff,
                         nearlyEmptyFlag: nearlyEmptyFlag_ff,
                         emptyFlag: emptyFlag_ff};

    // ==================================================
    // fifo pointers; fifoReset moves both, rewind only the read one
    always_ff @(posedge sys_clk) begin
        if (srst || fifoReset) begin
            wrPtr_ff <= PTR_RST;
            rdPtr_ff <= PTR_RST;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
        end
    end

    // full side flags change only on write side ticks
    always_ff @(posedge sys_clk) begin
        if (srst || fifoReset) begin
            fullFlag_ff <= `BRF_FULL_RST;
            nearlyFullFlag_ff <= `BRF_FULL_RST;
        end else if (writeSideClock) begin
            fullFlag_ff <= (nxtCount >= {1'b0, fullLvl});
            nearlyFullFlag_ff <= (nxtCount >= {1'b0, nfLvl});
        end
    end

    // empty side flags change only on read side ticks
    always_ff @(posedge sys_clk) begin
        if (srst || fifoReset) begin
            emptyFlag_ff <= `BRF_EMPTY_RST;
            nearlyEmptyFlag_ff <= `BRF_EMPTY_RST;
        end else if (readSideClock) begin
            emptyFlag_ff <= (nxtCount == '0);
            nearlyEmptyFlag_ff <= (nxtCount <= {1'b0, neLvl});
        end
    end

    // fetched word waits one cycle before entering the buffer
    always_ff @(posedge sys_clk) begin
        if (srst || fifoReset) begin
            fetchPend_ff <= 1'b0;
        end else begin
            fetchPend_ff <= doFetch;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (doFetch) fetchData_ff <= mem[rdPtr_ff[ADDR_W-1:0]];
    end

    // buffer back-pressure stalls fetches through fetchOk
    fifo_buf #(
        .WIDTH(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .sys_clk(sys_clk),
        .srst(srst),
        .clear(fifoReset),
        .inValid(fetchPend_ff),
        .inReady(bufReady),
        .inData(fetchData_ff),
        .outValid(readValid),
        .outReady(readReady),
        .outData(readData)
    );

    // ==================================================
    // memory ports
    port_ctl_t ctl [2]; // port controls as an array
    logic [ADDR_W-1:0] addr [2];
    logic [DATA_W-1:0] wdat [2];
    logic [DATA_W-1:0] rdat_ff [2]; // output latches
    logic portFire [2]; // port cycle this tick
    logic portClr [2]; // output latch clear

    assign ctl[0] = portACtl;
    assign ctl[1] = portBCtl;
    assign addr[0] = portAAddr;
    assign addr[1] = portBAddr;
    assign wdat[0] = portAWData;
    assign wdat[1] = portBWData;
    assign portClr[0] = portAOutputClear || !chipWideResetN;
    assign portClr[1] = portBOutputClear || !chipWideResetN;
    assign portARData = rdat_ff[0];
    assign portBRData = rdat_ff[1];

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            // ports are idle while the array serves as a fifo
            assign portFire[p] = !fifoMode && ctl[p].clkEn && ctl[p].ce;
            // array is read before this edge's write lands
            wire logic [DATA_W-1:0] oldWord = mem[addr[p]];
            logic [DATA_W-1:0] nxt_rdat;
            always_comb begin
                case (ctl[p].mode)
                    MODE_NORMAL: nxt_rdat = ctl[p].we ? rdat_ff[p] :
                                            oldWord;
                    MODE_THROUGH: nxt_rdat = ctl[p].we ? wdat[p] :
                                             oldWord;
                    MODE_RBW: nxt_rdat = oldWord;
                    default: nxt_rdat = rdat_ff[p]; // unused code holds
                endcase
            end
            if (ASYNC_OUT_CLEAR) begin : g_async
                // clear acts at once, no clock edge needed
                always_ff @(posedge sys_clk or posedge portClr[p]) begin
                    if (portClr[p]) rdat_ff[p] <= OUT_RST;
                    else if (srst) rdat_ff[p] <= OUT_RST;
                    else if (portFire[p]) rdat_ff[p] <= nxt_rdat;
                end
            end else begin : g_sync
                always_ff @(posedge sys_clk) begin
                    if (srst || portClr[p]) rdat_ff[p] <= OUT_RST;
                    else if (portFire[p]) rdat_ff[p] <= nxt_rdat;
                end
            end
        end
    endgenerate

    // ==================================================
    // array writes; port b wins an address collision
    always_ff @(posedge sys_clk) begin
        if (doWrite) mem[wrPtr_ff[ADDR_W-1:0]] <= writeData;
        if (portFire[0] && ctl[0].we) mem[addr[0]] <= wdat[0];
        if (portFire[1] && ctl[1].we) mem[addr[1]] <= wdat[1];
    end
endmodule : block_ram_fifo

// ===== logic/block_ram_fifo_map.svh
/*
 * constants of the block memory with fifo mode: widths, depths, reset
 * values and mode codes. assumes it is included by bare name; the guard skips repeats.
 */
`ifndef BLOCK_RAM_FIFO_MAP_SVH
`define BLOCK_RAM_FIFO_MAP_SVH

// ==================================================
// sizes
`define BRF_ADDR_W 9
`define BRF_DATA_W 9
`define BRF_BUF_DEPTH 8

// ==================================================
// write mode codes
`define BRF_MODE_NORMAL 2'h0
`define BRF_MODE_THROUGH 2'h1
`define BRF_MODE_RBW 2'h2

// ==================================================
// reset values
`define BRF_OUT_RST 1'h0
`define BRF_PTR_RST 1'h0
`define BRF_FULL_RST 1'h0
`define BRF_EMPTY_RST 1'h1

`endif

// ===== logic/block_ram_fifo_pkg.sv
/*
 * types shared by the block memory and its testbench.
 * assumes block_ram_fifo_map.svh is on the include path.
 */
`include "block_ram_fifo_map.svh"

package block_ram_fifo_pkg;
    // ==================================================
    // per-port write behaviour
    typedef enum logic [1:0] {
        MODE_NORMAL = `BRF_MODE_NORMAL,
        MODE_THROUGH = `BRF_MODE_THROUGH,
        MODE_RBW = `BRF_MODE_RBW
    } wr_mode_t;

    // control bits of one memory port
    typedef struct packed {
        logic clkEn; // port clock tick
        logic ce; // port clock enable
        logic we; // write strobe
        wr_mode_t mode; // write behaviour
    } port_ctl_t;

    // fifo status flags
    typedef struct packed {
        logic fullFlag;
        logic nearlyFullFlag;
        logic nearlyEmptyFlag;
        logic emptyFlag;
    } fifo_flags_t;
endpackage : block_ram_fifo_pkg

// ===== bench/block_ram_fifo_asserts.sv
/* checker for the block memory ports and fifo flags.
   assumes output clears are synchronous (ASYNC_OUT_CLEAR 0). */
`timescale 1ns/1ns
`include "block_ram_fifo_map.svh"
module block_ram_fifo_asserts import block_ram_fifo_pkg::*; (
    input wire logic sys_clk, // clock
    input wire logic srst, // sync reset
    input wire logic chipWideResetN, // clears both
    input wire port_ctl_t portACtl, // a ctl
    input wire logic [`BRF_DATA_W-1:0] portAWData, // a wdata
    input wire logic portAOutputClear, // a clear
    input wire logic [`BRF_DATA_W-1:0] portARData, // a out
    input wire port_ctl_t portBCtl, // b ctl
    input wire logic portBOutputClear, // b clear
    input wire logic [`BRF_DATA_W-1:0] portBRData, // b out
    input wire logic fifoMode, // fifo on
    input wire logic fifoReset, // fifo reset
    input wire logic readPointerRewind, // rewind
    input wire logic writeSideClock, // write tick
    input wire logic readSideClock, // read tick
    input wire logic readClockEnable, // read enable
    input wire logic fetchStrobe, // fetch
    input wire fifo_flags_t fifoFlags, // flags
    input wire logic fetchReady, // fetch taken
    input wire logic readValid // word ready
);
    // ==================================================
    // helpers
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // a port cycle with no clear pending
    wire logic aFree = !fifoMode && portACtl.clkEn && portACtl.ce
        && !portAOutputClear && chipWideResetN;
    wire logic bCyc = !fifoMode && portBCtl.clkEn && portBCtl.ce;
    // rewind wins over a fetch, so it is left out
    wire logic fetchGo = fifoMode && readSideClock && readClockEnable
        && fetchStrobe && fetchReady && !fifoReset && !readPointerRewind;
    // ==================================================
    // assertions
    normal_hold_a: assert property (aFree && portACtl.we &&
        portACtl.mode == MODE_NORMAL |=> $stable(portARData))
        else $error("output moved on normal write");
    through_data_a: assert property (aFree && portACtl.we &&
        portACtl.mode == MODE_THROUGH |=> portARData == $past(portAWData))
        else $error("write data not shown");
    full_tick_a: assert property (!$stable(fifoFlags[3:2]) |->
        $past(writeSideClock) || $past(fifoReset) || $past(srst))
        else $error("full flags moved off write tick");
    empty_tick_a: assert property (!$stable(fifoFlags[1:0]) |->
        $past(readSideClock) || $past(fifoReset) || $past(srst))
        else $error("empty flags moved off read tick");
    fifo_clear_a: assert property (fifoReset |=> fifoFlags == 4'h3)
        else $error("flags not cleared by fifo reset");
    reset_flags_a: assert property ($fell(srst) |-> fifoFlags == 4'h3)
        else $error("flags wrong after reset");
    a_clear_a: assert property (portAOutputClear |=> portARData == '0)
        else $error("port a not cleared");
    b_keep_a: assert property (portAOutputClear && !portBOutputClear
        && chipWideResetN && !bCyc |=> $stable(portBRData))
        else $error("port b hit by port a clear");
    chip_clear_a: assert property (!chipWideResetN |=>
        portARData == '0 && portBRData == '0)
        else $error("chip reset left output");
    fetch_lat_a: assert property (fetchGo ##1 !fifoReset |->
        ##1 readValid) else $error("fetched word late");
    // ==================================================
    // covers
    rbw_c: cover property (aFree && portACtl.mode == MODE_RBW);
    fetch_c: cover property (fetchGo);
    full_c: cover property (fifoFlags.fullFlag);
endmodule : block_ram_fifo_asserts

bind block_ram_fifo block_ram_fifo_asserts chk (.sys_clk(sys_clk),
    .srst(srst), .chipWideResetN(chipWideResetN), .portACtl(portACtl),
    .portAWData(portAWData), .portAOutputClear(portAOutputClear),
    .portARData(portARData), .portBCtl(portBCtl), .fifoMode(fifoMode),
    .portBOutputClear(portBOutputClear), .portBRData(portBRData),
    .fifoReset(fifoReset), .readPointerRewind(readPointerRewind),
    .writeSideClock(writeSideClock), .readSideClock(readSideClock),
    .readClockEnable(readClockEnable), .fetchStrobe(fetchStrobe),
    .fifoFlags(fifoFlags), .fetchReady(fetchReady), .readValid(readValid));

// ===== bench/fifo_drain_model.sv
/* user logic draining the read buffer with random stalls.
   assumes one clock, sync reset high. */
`timescale 1ns/1ns
module fifo_drain_model (
    input wire logic sys_clk, // clock
    input wire logic srst, // sync reset
    input wire logic readValid, // word offered
    output logic readReady // accepts word
);
    int seed = 32'h5A17; // own stream, apart from the bench
    // ==================================================
    // stall about one cycle in four, so words wait in the buffer
    initial readReady = 1'b0;
    always @(posedge sys_clk) begin
        readReady <= !srst && ($random(seed) % 4 != 0);
    end
endmodule : fifo_drain_model

// ===== bench/testbench.sv
/* self-checking bench for the block memory and its fifo mode.
   assumes the design defaults: 9-bit address and data. */
`timescale 1ns/1ns
module testbench import block_ram_fifo_pkg::*; ;
    logic sys_clk, srst, chipWideResetN; // clock and resets
    port_ctl_t aCtl, bCtl; // port controls
    logic [8:0] aAddr, bAddr, aWData, bWData, aRData, bRData; // ports
    logic aClr, bClr, fifoMode, fifoReset, rewind; // clears, modes
    logic wTick, wEn, wStb, rTick, rEn, fStb, readReady; // fifo ctl
    logic [8:0] wData, fThr, nfThr, neThr, readData, d; // fifo data
    fifo_flags_t flags; // status
    logic fetchReady, readValid; // read side status
    int seed = 32'h918CACF9;
    int n_errors = 0;
    int n_checks = 0;
    logic [8:0] mem [8]; // bench copy of the used words
    logic [8:0] last [2]; // last output of each port
    logic [8:0] expQ [$], got [$]; // written and drained words
    wr_mode_t modes [3] = '{MODE_NORMAL, MODE_THROUGH, MODE_RBW};

    block_ram_fifo dut (.sys_clk(sys_clk), .srst(srst),
        .chipWideResetN(chipWideResetN), .portACtl(aCtl),
        .portAAddr(aAddr), .portAWData(aWData), .portAOutputClear(aClr),
        .portARData(aRData), .portBCtl(bCtl), .portBAddr(bAddr),
        .portBWData(bWData), .portBOutputClear(bClr), .portBRData(bRData),
        .fifoMode(fifoMode), .fifoReset(fifoReset),
        .readPointerRewind(rewind), .writeSideClock(wTick),
        .writeClockEnable(wEn), .writeStrobe(wStb), .writeData(wData),
        .readSideClock(rTick), .readClockEnable(rEn), .fetchStrobe(fStb),
        .fullThr(fThr), .nearlyFullThr(nfThr), .nearlyEmptyThr(neThr),
        .fifoFlags(flags), .fetchReady(fetchReady), .readValid(readValid),
        .readReady(readReady), .readData(readData));
    fifo_drain_model drain (.sys_clk(sys_clk), .srst(srst),
        .readValid(readValid), .readReady(readReady));

    // ==================================================
    // checks and expectations
    task chkData(input logic [8:0] act, input logic [8:0] exp);
        n_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("[ERR] %0t data %h exp %h", $time, act, exp);
        end
    endtask : chkData
    task chkFlags(input fifo_flags_t act, input fifo_flags_t exp);
        n_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("[ERR] %0t flags %h exp %h", $time, act, exp);
        end
    endtask : chkFlags
    // a threshold brought into its legal range, zero counts as one
    function automatic int clampLvl(input int v, input int hi);
        return (v == 0) ? 1 : (v > hi) ? hi : v;
    endfunction : clampLvl
    function automatic fifo_flags_t expFlags(input int c);
        int f;
        int s;
        f = clampLvl(fThr, 511); // largest full level for 9 address bits
        s = (f == 1) ? 1 : f - 1;
        return '{c >= f, c >= clampLvl(nfThr, s),
                 c <= clampLvl(neThr, s), c == 0};
    endfunction : expFlags
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ==================================================
    // one port cycle, then the output against the mode
    task portOp(input bit b, input bit we, input wr_mode_t m,
        input logic [2:0] a, input logic [8:0] dat);
        logic [8:0] e;
        @(posedge sys_clk);
        if (b) begin
            bCtl <= '{1'b1, 1'b1, we, m};
            bAddr <= 9'(a);
            bWData <= dat;
        end else begin
            aCtl <= '{1'b1, 1'b1, we, m};
            aAddr <= 9'(a);
            aWData <= dat;
        end
        @(posedge sys_clk);
        aCtl <= '0;
        bCtl <= '0;
        e = !we ? mem[a] : m == MODE_THROUGH ? dat
            : m == MODE_RBW ? mem[a] : last[b];
        if (we) mem[a] = dat;
        last[b] = e;
        #1 chkData(b ? bRData : aRData, e);
    endtask : portOp

    // fetch until n words came out, then a few fetches on empty
    task drainN(input int n);
        got.delete();
        @(posedge sys_clk);
        fStb <= 1'b1;
        for (int k = 0; k < 300 && got.size() < n; k++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        fStb <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chkData(9'(got.size()), 9'(n));
        for (int i = 0; i < n; i++) chkData(got[i], expQ[i]);
        chkFlags(flags, expFlags(0));
        chkData(9'(fetchReady), 9'h000);
    endtask : drainN

    always @(posedge sys_clk) begin
        if (readValid === 1'b1 && readReady === 1'b1) got.push_back(readData);
    end
    // read side ticks at half rate, so empty flags must wait for a tick
    always @(posedge sys_clk) rTick <= !rTick;

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // watchdog: the run needs a few hundred cycles
    initial begin
        #400000;
        n_errors++;
        give_verdict();
    end

    // ==================================================
    // main sequence
    initial begin
        {srst, chipWideResetN, wTick, wEn, rTick, rEn} = 6'h3F;
        {aCtl, bCtl, aClr, bClr, fifoMode, fifoReset, rewind} = '0;
        {aAddr, bAddr, aWData, bWData, wData, wStb, fStb} = '0;
        {fThr, nfThr, neThr} = {9'h005, 9'h004, 9'h002};
        last = '{9'h000, 9'h000};
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) portOp(i[0], 1'b1, MODE_THROUGH,
            i[2:0], 9'($random(seed)));
        foreach (modes[m]) portOp(1'b0, 1'b1, modes[m], 3'h7, 9'h1FF);
        for (int i = 0; i < 30; i++) portOp(1'($random(seed)),
            1'($random(seed)), modes[$unsigned($random(seed)) % 3],
            3'($random(seed)), 9'($random(seed)));
        @(posedge sys_clk);
        aClr <= 1'b1;
        @(posedge sys_clk);
        aClr <= 1'b0;
        #1 chkData(aRData, 9'h000);
        chkData(bRData, last[1]);
        @(posedge sys_clk);
        chipWideResetN <= 1'b0;
        @(posedge sys_clk);
        chipWideResetN <= 1'b1;
        #1 chkData(aRData | bRData, 9'h000);
        $display("test ports done");
        @(posedge sys_clk);
        fifoMode <= 1'b1;
        // write side ticks every other cycle; the sixth word meets full
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            wStb <= 1'b1;
            wTick <= i[0];
            if (!i[0]) begin
                d = 9'($random(seed));
                wData <= d;
                if (i < 10) expQ.push_back(d);
            end
        end
        @(posedge sys_clk);
        wStb <= 1'b0;
        wTick <= 1'b1;
        #1 chkFlags(flags, expFlags(5));
        drainN(5);
        @(posedge sys_clk);
        rewind <= 1'b1;
        @(posedge sys_clk);
        rewind <= 1'b0;
        drainN(5);
        @(posedge sys_clk);
        rewind <= 1'b1;
        @(posedge sys_clk);
        rewind <= 1'b0;
        fifoReset <= 1'b1;
        @(posedge sys_clk);
        fifoReset <= 1'b0;
        #1 chkFlags(flags, expFlags(0));
        drainN(0);
        // out-of-range thresholds: zero full level and a too high nearly-full
        @(posedge sys_clk);
        fThr <= 9'h000;
        nfThr <= 9'h1FF;
        wStb <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wStb <= 1'b0;
        #1 chkFlags(flags, expFlags(1));
        $display("test fifo done");
        give_verdict();
    end
endmodule : testbench
